// ---- core/dma_handshake_defs.vh ----
// Constants for the bus-master handshake and timeout block
`ifndef DMA_HANDSHAKE_DEFS_VH
`define DMA_HANDSHAKE_DEFS_VH

// Clock and handshake allotment
`define CLK_MHZ          50
`define HS_ALLOT_NS      10500
`define HS_CYCLES        ((`HS_ALLOT_NS * `CLK_MHZ + 999) / 1000)
`define WORD_CYCLES      2'h3
`define STROBE_FIRST     2'h1
`define STROBE_LAST      2'h2

// Register byte offsets
`define OFF_CTRL         12'h000
`define OFF_STATUS       12'h004
`define OFF_BITWORD      12'h008
`define OFF_BLKSTAT      12'h00c
`define OFF_TMOCOUNT     12'h010

// Control fields
`define CTRL_MODE_LO     0
`define CTRL_CFG_LO      2
`define CTRL_IRQEN       4
`define CTRL_RESET       5'h00

// Status / sticky bit positions
`define ST_HSFAIL        0
`define ST_FRAMEHALT     1
`define ST_BUSY          2
`define ST_INHIBIT       3
`define BIT_HSFAIL       0
`define BS_EOM           0
`define BS_ERROR         1

// Operating modes
`define MODE_BC          2'h0
`define MODE_RT          2'h1
`define MODE_SMON        2'h2
`define MODE_WMON        2'h3

// Host configurations
`define CFG_BUFFERED     2'h0
`define CFG_TRANSPARENT  2'h1
`define CFG_DMA          2'h2

// Transfer sequence kinds
`define SEQ_DATA         3'h0
`define SEQ_SOM          3'h1
`define SEQ_EOM          3'h2
`define SEQ_RETRY        3'h3
`define SEQ_WMSTART      3'h4

`endif

// ---- core/dma_bus_handshake_timeout.v ----
// Bus-master memory handshake with handshake timeout and APB registers
`timescale 1ns/10ps
`include "dma_handshake_defs.vh"

module dma_bus_handshake_timeout #(
    parameter CNT_W     = 8,
    parameter TMR_W     = 12,
    parameter HS_CYCLES = `HS_CYCLES
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             ce,
    input  wire [11:0]      paddr,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output wire             pready,
    output wire             pslverr,
    input  wire             xferValid,
    output wire             xferReady,
    input  wire             xferWrite,
    input  wire [2:0]       xferSeq,
    input  wire [CNT_W-1:0] xferWords,
    input  wire [15:0]      xferAddr,
    input  wire [15:0]      wrData,
    output reg              wordDone,
    output reg  [15:0]      rdData,
    output reg              xferDone,
    output reg              xferTimeout,
    input  wire             messageStart,
    output reg              transferRequestN,
    input  wire             busGrantN,
    output reg              busAcknowledgeN,
    output reg              memOutputEnableN,
    output reg              memWriteStrobeN,
    output reg  [15:0]      memAddr,
    output reg  [15:0]      memDataOut,
    output reg              memDataOe,
    input  wire [15:0]      memDataIn,
    input  wire             hostStrobeN,
    input  wire             hostHandshakeN,
    output reg              abortMessage,
    output reg              stopTransmit,
    output reg              storeInhibit,
    output wire             keepErrorCheck,
    output reg              dropWordPair,
    output reg              ignoreMessage,
    output reg              bsEomSet,
    output reg              bsErrorSet,
    output wire             hsFailIrq
);

    // One-hot states
    localparam S_IDLE = 3'b001;
    localparam S_REQ  = 3'b010;
    localparam S_ACK  = 3'b100;

    reg  [2:0]       state_reg;
    reg  [2:0]       state_next;
    reg  [1:0]       phase_reg;
    reg  [CNT_W-1:0] words_reg;
    reg              write_reg;
    reg  [2:0]       seq_reg;
    reg  [TMR_W-1:0] reqTmr_reg;
    reg  [TMR_W-1:0] stbTmr_reg;
    reg  [4:0]       ctrl_reg;
    reg              hsFail_reg;
    reg              frameHalt_reg;
    reg              bitFail_reg;
    reg              bsEom_reg;
    reg              bsErr_reg;
    reg  [15:0]      tmoCount_reg;
    reg  [2:0]       grantSync_reg;
    reg  [2:0]       strobeSync_reg;
    reg              grantLow_reg;
    reg              strobeLow_reg;
    reg  [31:0]      rdMux;

    wire [1:0] mode = ctrl_reg[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
    wire [1:0] cfg  = ctrl_reg[`CTRL_CFG_LO+1:`CTRL_CFG_LO];
    wire       irqEn = ctrl_reg[`CTRL_IRQEN];
    wire       isDma = (cfg == `CFG_DMA);
    wire       isBuffered = (cfg == `CFG_BUFFERED);
    wire       msgMode = (mode == `MODE_BC) || (mode == `MODE_RT) ||
                         (mode == `MODE_SMON);
    wire       lastPhase = (phase_reg == `WORD_CYCLES);
    wire       lastWord  = (words_reg == {CNT_W{1'b0}});
    wire [TMR_W-1:0] tmrLimit = HS_CYCLES[TMR_W-1:0] - {{(TMR_W-1){1'b0}}, 1'b1};

    // Timeout only guards data words and RT/MM start; never buffered
    wire seqGuarded = (seq_reg == `SEQ_DATA) ||
                      ((seq_reg == `SEQ_SOM) &&
                       (mode == `MODE_RT || mode == `MODE_SMON));
    wire reqTiming  = (state_reg == S_REQ) && seqGuarded && !isBuffered;
    // Strobe hold is not timed inside the unguarded sequences
    wire stbTiming  = !isBuffered && !hostHandshakeN && strobeLow_reg &&
                      (state_reg == S_IDLE || seqGuarded);
    wire reqTmo     = reqTiming && (reqTmr_reg == tmrLimit);
    wire stbTmo     = stbTiming && (stbTmr_reg == tmrLimit);
    wire tmoEvt     = reqTmo || stbTmo;

    // APB: zero-wait slave, writes at the access phase, read data sampled at the setup phase
    wire apbAcc = psel && penable;
    wire apbWr  = apbAcc && pwrite && ce;
    wire mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) ||
                  (paddr == `OFF_BITWORD) || (paddr == `OFF_BLKSTAT) ||
                  (paddr == `OFF_TMOCOUNT);
    assign pready  = 1'b1;
    assign pslverr = apbAcc && !mapped;

    // Write-one-to-clear strobes for sticky flags
    wire wrStatus = apbWr && (paddr == `OFF_STATUS);
    wire clrHsFail = wrStatus && pwdata[`ST_HSFAIL];
    wire clrHalt   = wrStatus && pwdata[`ST_FRAMEHALT];
    wire clrBit    = apbWr && (paddr == `OFF_BITWORD) && pwdata[`BIT_HSFAIL];
    wire wrBlk     = apbWr && (paddr == `OFF_BLKSTAT);

    assign xferReady      = ce && (state_reg == S_IDLE) && !frameHalt_reg;
    assign hsFailIrq      = hsFail_reg && irqEn;
    assign keepErrorCheck = storeInhibit && (mode == `MODE_RT);

    // Read mux
    always @* begin
        rdMux = 32'h0000_0000;
        case (paddr)
            `OFF_CTRL:     rdMux[4:0] = ctrl_reg;
            `OFF_STATUS: begin
                rdMux[`ST_HSFAIL]    = hsFail_reg;
                rdMux[`ST_FRAMEHALT] = frameHalt_reg;
                rdMux[`ST_BUSY]      = (state_reg != S_IDLE);
                rdMux[`ST_INHIBIT]   = storeInhibit;
            end
            `OFF_BITWORD:  rdMux[`BIT_HSFAIL] = bitFail_reg;
            `OFF_BLKSTAT: begin
                rdMux[`BS_EOM]   = bsEom_reg;
                rdMux[`BS_ERROR] = bsErr_reg;
            end
            `OFF_TMOCOUNT: rdMux[15:0] = tmoCount_reg;
            default:       rdMux = 32'h0000_0000;
        endcase
    end

    // Read data is taken at the setup phase so it stands through the access
    always @(posedge clk) begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (ce && psel && !penable)
            prdata <= rdMux;
    end

    // Pin synchronisers: a change counts once stages two and three agree
    always @(posedge clk) begin
        if (!resetn) begin
            grantSync_reg  <= 3'h7;
            strobeSync_reg <= 3'h7;
            grantLow_reg   <= 1'b0;
            strobeLow_reg  <= 1'b0;
        end else if (ce) begin
            grantSync_reg  <= {grantSync_reg[1:0], busGrantN};
            strobeSync_reg <= {strobeSync_reg[1:0], hostStrobeN};
            if (grantSync_reg[1] == grantSync_reg[2])
                grantLow_reg <= !grantSync_reg[2];
            if (strobeSync_reg[1] == strobeSync_reg[2])
                strobeLow_reg <= !strobeSync_reg[2];
        end
    end

    // Sequencer next state; a timeout gives the buses back at once
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (xferValid && xferReady)
                    state_next = isDma ? S_REQ : S_ACK;
            end
            S_REQ: begin
                if (reqTmo)
                    state_next = S_IDLE;
                else if (grantLow_reg)
                    state_next = S_ACK;
            end
            S_ACK: begin
                if (stbTmo || (lastPhase && lastWord))
                    state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    // Sequencer registers and memory strobes
    always @(posedge clk) begin
        if (!resetn) begin
            state_reg        <= S_IDLE;
            phase_reg        <= 2'h0;
            words_reg        <= {CNT_W{1'b0}};
            write_reg        <= 1'b0;
            seq_reg          <= `SEQ_DATA;
            transferRequestN <= 1'b1;
            busAcknowledgeN  <= 1'b1;
            memOutputEnableN <= 1'b1;
            memWriteStrobeN  <= 1'b1;
            memAddr          <= 16'h0000;
            memDataOut       <= 16'h0000;
            memDataOe        <= 1'b0;
            rdData           <= 16'h0000;
            wordDone         <= 1'b0;
            xferDone         <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            wordDone  <= 1'b0;
            xferDone  <= 1'b0;
            // Request is held from accept until grant or timeout
            transferRequestN <= !(state_next == S_REQ);
            // Acknowledge low for four cycles per word of the burst
            busAcknowledgeN  <= !(state_next == S_ACK);
            if (state_reg == S_IDLE && state_next != S_IDLE) begin
                words_reg  <= xferWords;
                write_reg  <= xferWrite;
                seq_reg    <= xferSeq;
                memAddr    <= xferAddr;
                memDataOut <= wrData;
                phase_reg  <= 2'h0;
            end
            if (state_reg == S_ACK) begin
                phase_reg <= phase_reg + 2'h1;
                if (phase_reg == `STROBE_LAST && !write_reg)
                    rdData <= memDataIn;
                if (lastPhase) begin
                    wordDone <= 1'b1;
                    if (lastWord)
                        xferDone <= !stbTmo;
                    else begin
                        words_reg  <= words_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                        memAddr    <= memAddr + 16'h0001;
                        memDataOut <= wrData;
                    end
                end
            end
            // One strobe per word in the middle two cycles of its slot
            memOutputEnableN <= !(state_next == S_ACK && !write_reg &&
                                  state_reg == S_ACK &&
                                  phase_reg >= (`STROBE_FIRST - 2'h1) &&
                                  phase_reg < `STROBE_LAST);
            memWriteStrobeN  <= !(state_next == S_ACK && write_reg &&
                                  state_reg == S_ACK &&
                                  phase_reg >= (`STROBE_FIRST - 2'h1) &&
                                  phase_reg < `STROBE_LAST);
            // Direction of a new transfer is known only from its request
            memDataOe        <= (state_next == S_ACK) &&
                                ((state_reg == S_IDLE) ? xferWrite : write_reg);
        end
    end

    // Handshake timers: count cycles, restart whenever the wait ends
    always @(posedge clk) begin
        if (!resetn) begin
            reqTmr_reg <= {TMR_W{1'b0}};
            stbTmr_reg <= {TMR_W{1'b0}};
        end else if (ce) begin
            if (reqTiming && !grantLow_reg && !reqTmo)
                reqTmr_reg <= reqTmr_reg + {{(TMR_W-1){1'b0}}, 1'b1};
            else
                reqTmr_reg <= {TMR_W{1'b0}};
            if (stbTiming && !stbTmo)
                stbTmr_reg <= stbTmr_reg + {{(TMR_W-1){1'b0}}, 1'b1};
            else
                stbTmr_reg <= {TMR_W{1'b0}};
        end
    end

    // Timeout consequences; pulses last one cycle
    always @(posedge clk) begin
        if (!resetn) begin
            abortMessage  <= 1'b0;
            stopTransmit  <= 1'b0;
            storeInhibit  <= 1'b0;
            dropWordPair  <= 1'b0;
            ignoreMessage <= 1'b0;
            bsEomSet      <= 1'b0;
            bsErrorSet    <= 1'b0;
            xferTimeout   <= 1'b0;
        end else if (ce) begin
            xferTimeout   <= tmoEvt;
            abortMessage  <= tmoEvt && msgMode;
            stopTransmit  <= tmoEvt && (mode == `MODE_BC ||
                                        mode == `MODE_RT);
            bsEomSet      <= tmoEvt && msgMode;
            bsErrorSet    <= tmoEvt && msgMode;
            dropWordPair  <= tmoEvt && (mode == `MODE_WMON);
            ignoreMessage <= reqTmo && (mode == `MODE_RT) &&
                             (seq_reg == `SEQ_SOM);
            // Inhibit lasts to the next message; a timeout wins over it
            if (tmoEvt && msgMode)
                storeInhibit <= 1'b1;
            else if (messageStart)
                storeInhibit <= 1'b0;
        end
    end

    // Software registers and sticky flags; hardware set wins over clear
    always @(posedge clk) begin
        if (!resetn) begin
            ctrl_reg      <= `CTRL_RESET;
            hsFail_reg    <= 1'b0;
            frameHalt_reg <= 1'b0;
            bitFail_reg   <= 1'b0;
            bsEom_reg     <= 1'b0;
            bsErr_reg     <= 1'b0;
            tmoCount_reg  <= 16'h0000;
        end else if (ce) begin
            if (apbWr && paddr == `OFF_CTRL)
                ctrl_reg <= pwdata[4:0];
            hsFail_reg    <= (hsFail_reg && !clrHsFail) || tmoEvt;
            // BC frame stays halted until software releases it
            frameHalt_reg <= (frameHalt_reg && !clrHalt) ||
                             (tmoEvt && mode == `MODE_BC);
            bitFail_reg   <= (bitFail_reg && !clrBit) ||
                             (tmoEvt && mode == `MODE_RT);
            bsEom_reg     <= (bsEom_reg && !(wrBlk && pwdata[`BS_EOM])) ||
                             (tmoEvt && msgMode);
            bsErr_reg     <= (bsErr_reg && !(wrBlk && pwdata[`BS_ERROR])) ||
                             (tmoEvt && msgMode);
            if (tmoEvt)
                tmoCount_reg <= tmoCount_reg + 16'h0001;
        end
    end

endmodule

// ---- tb/host_bus_model.sv ----
// Host processor model: grants the shared buses and answers memory reads
`timescale 1ns/10ps
module host_bus_model (
    input  wire        clk,
    input  wire        resetn,
    input  wire [15:0] grantDelay,
    input  wire        transferRequestN,
    input  wire        busAcknowledgeN,
    input  wire        memOutputEnableN,
    input  wire [15:0] memAddr,
    output reg         busGrantN,
    output wire [15:0] memDataIn
);
    reg [15:0] waitCnt_reg;

    // Grant after the set delay and hold it until the request is withdrawn
    always @(posedge clk) begin
        if (!resetn || transferRequestN) begin
            busGrantN   <= 1'b1;
            waitCnt_reg <= 16'h0000;
        end else if (waitCnt_reg >= grantDelay) begin
            busGrantN <= 1'b0;
        end else begin
            waitCnt_reg <= waitCnt_reg + 16'h0001;
        end
    end

    // Outside the read strobe the bus shows the inverse pattern, so stale data never matches
    // Page register supplies the upper address only while the terminal holds the buses
    wire [7:0]  upperAddr = busAcknowledgeN ? 8'h00 : 8'h5a;
    wire [15:0] pattern   = memAddr ^ {upperAddr, 8'h5a};
    assign memDataIn = memOutputEnableN ? ~pattern : pattern;
endmodule

// ---- tb/dma_bus_handshake_timeout_sva.sv ----
// Assertions on the bus handshake and timeout outputs
`timescale 1ns/10ps
module dma_bus_handshake_timeout_sva (
    input wire clk,
    input wire resetn,
    input wire transferRequestN,
    input wire busGrantN,
    input wire busAcknowledgeN,
    input wire memOutputEnableN,
    input wire memWriteStrobeN,
    input wire memDataOe,
    input wire xferDone,
    input wire xferTimeout,
    input wire abortMessage,
    input wire stopTransmit,
    input wire dropWordPair,
    input wire bsEomSet,
    input wire bsErrorSet
);
    reg [7:0] ackCnt_reg;

    // Length of the current acknowledge window in cycles
    always @(posedge clk) begin
        ackCnt_reg <= (!resetn || busAcknowledgeN) ? 8'h00 : ackCnt_reg + 8'h01;
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_REQ_BEFORE_ACK: assert property ($fell(transferRequestN) |-> busAcknowledgeN)
        else $error("acknowledge already low when request raised");
    AST_GRANT_TO_ACK: assert property ($fell(busGrantN) && !transferRequestN |-> ##[1:6] !busAcknowledgeN)
        else $error("no acknowledge after grant");
    AST_ACK_WORDS: assert property ($rose(busAcknowledgeN) && xferDone |-> ackCnt_reg != 8'h00 && ackCnt_reg[1:0] == 2'b00)
        else $error("acknowledge not four cycles per word");
    AST_READ_IN_ACK: assert property (!memOutputEnableN |-> !busAcknowledgeN)
        else $error("output enable outside acknowledge");
    AST_ONE_STROBE: assert property (memOutputEnableN || memWriteStrobeN)
        else $error("read and write strobes together");
    AST_WRITE_DRIVEN: assert property (!memWriteStrobeN |-> memDataOe && !busAcknowledgeN)
        else $error("write strobe without driven data");
    AST_STATUS_PAIR: assert property (bsEomSet || bsErrorSet |-> bsEomSet && bsErrorSet && xferTimeout)
        else $error("block status flags not paired with timeout");
    AST_ABORT_CAUSE: assert property (abortMessage || stopTransmit |-> xferTimeout && abortMessage)
        else $error("abort without timeout");
    AST_WMON_DROP: assert property (dropWordPair |-> xferTimeout && !abortMessage)
        else $error("word pair dropped without timeout");
endmodule

bind dma_bus_handshake_timeout dma_bus_handshake_timeout_sva chk (.clk(clk), .resetn(resetn),
    .transferRequestN(transferRequestN), .busGrantN(busGrantN),
    .busAcknowledgeN(busAcknowledgeN), .memOutputEnableN(memOutputEnableN),
    .memWriteStrobeN(memWriteStrobeN), .memDataOe(memDataOe), .xferDone(xferDone),
    .xferTimeout(xferTimeout), .abortMessage(abortMessage), .stopTransmit(stopTransmit),
    .dropWordPair(dropWordPair), .bsEomSet(bsEomSet), .bsErrorSet(bsErrorSet));

// ---- tb/dma_bus_handshake_timeout_bench.sv ----
// Self-checking bench for the bus handshake and timeout block
`timescale 1ns/10ps
`include "dma_handshake_defs.vh"
module dma_bus_handshake_timeout_bench;
    reg         clk, resetn, ce, psel, penable, pwrite, xferValid, xferWrite;
    reg         messageStart, hostStrobeN, hostHandshakeN, slvErr, gotDone, gotTmo, badData;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rv;
    reg  [2:0]  xferSeq, sq;
    reg  [7:0]  xferWords;
    reg  [15:0] xferAddr, wrData, grantDelay;
    reg  [4:0]  obs;
    wire [31:0] prdata;
    wire [15:0] rdData, memAddr, memDataOut, memDataIn;
    wire        pready, pslverr, xferReady, wordDone, xferDone, xferTimeout, busGrantN;
    wire        transferRequestN, busAcknowledgeN, memOutputEnableN, memWriteStrobeN;
    wire        memDataOe, abortMessage, stopTransmit, storeInhibit, keepErrorCheck;
    wire        dropWordPair, ignoreMessage, bsEomSet, bsErrorSet, hsFailIrq;
    integer     n_errors, cmp_count, acks, oeLow, wrLow, reqLow, wd, i, k, m;

    dma_bus_handshake_timeout #(.HS_CYCLES(8)) dut (.*);
    host_bus_model host (.clk(clk), .resetn(resetn), .grantDelay(grantDelay),
        .transferRequestN(transferRequestN), .busAcknowledgeN(busAcknowledgeN),
        .memOutputEnableN(memOutputEnableN),
        .memAddr(memAddr), .busGrantN(busGrantN), .memDataIn(memDataIn));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Effect pulses last one cycle, so latch them; a new request clears the record
    always @(posedge clk)
        obs <= (xferValid ? 5'h00 : obs) |
               {ignoreMessage, dropWordPair, stopTransmit, abortMessage, bsEomSet};

    task chk(input [63:0] seen, input [63:0] exp, input [127:0] what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // One APB transfer; an idle cycle after it keeps psel from being set twice
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rv = prdata;
            slvErr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rv, exp, "register");
        end
    endtask
    // Issue one transfer and tally the memory strobes until it ends
    task xfer(input w, input [2:0] s, input [7:0] nw);
        begin
            xferWrite <= w;
            xferSeq <= s;
            xferWords <= nw;
            xferAddr <= 16'h0100;
            wrData <= 16'hc3a5;
            xferValid <= 1'b1;
            @(posedge clk);
            while (xferReady !== 1'b1) @(posedge clk);
            xferValid <= 1'b0;
            {acks, oeLow, wrLow, reqLow, wd, gotDone, gotTmo, badData} = 0;
            for (i = 0; i < 400 && !gotDone && !gotTmo; i = i + 1) begin
                @(posedge clk);
                acks = acks + (busAcknowledgeN === 1'b0);
                oeLow = oeLow + (memOutputEnableN === 1'b0);
                wrLow = wrLow + (memWriteStrobeN === 1'b0);
                reqLow = reqLow + (transferRequestN === 1'b0);
                wd = wd + (wordDone === 1'b1);
                if (memWriteStrobeN === 1'b0 && memDataOut !== wrData) badData = 1'b1;
                gotDone = (xferDone === 1'b1);
                gotTmo = (xferTimeout === 1'b1);
            end
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_errors = n_errors + 1;
        final_report;
    end

    initial begin
        {psel, penable, pwrite, xferValid, xferWrite, messageStart, resetn} = 7'h00;
        {hostStrobeN, hostHandshakeN, ce} = 3'h7;
        {paddr, pwdata, xferSeq, xferWords, xferAddr, wrData, grantDelay, obs} = 0;
        {n_errors, cmp_count} = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Registers read zero after reset; the sixth word is unmapped
        for (k = 0; k < 6; k = k + 1) begin
            rd({k[9:0], 2'b00}, 32'h0);
            chk(slvErr, k == 5, "slave error");
        end
        $display("test reset done");
        // DMA single read with a prompt grant
        apb(1'b1, `OFF_CTRL, 32'h19);
        xfer(1'b0, `SEQ_DATA, 8'h00);
        chk(gotDone & (reqLow > 0), 1, "granted read");
        chk({acks, wd}, {32'd4, 32'd1}, "ack cycles");
        chk({oeLow, wrLow}, {32'd2, 32'd0}, "strobes");
        chk(rdData, 16'h0100 ^ 16'h5a5a, "read data");
        // Write bursts in unguarded sequences survive a late grant
        grantDelay <= 16'd20;
        for (k = 0; k < 4; k = k + 1) begin
            m = (k == 2) ? 3 : (k == 3) ? 1 : 0;
            sq = (k == 1) ? `SEQ_RETRY : (k == 2) ? `SEQ_WMSTART : `SEQ_EOM;
            apb(1'b1, `OFF_CTRL, 32'h18 | m);
            xfer(1'b1, sq, 8'h03);
            chk({gotDone, gotTmo}, 2'b10, "late grant");
            chk({acks, wrLow}, {32'd16, 32'd8}, "burst length");
            chk(badData, 0, "write data");
            chk({wd, memAddr}, {32'd4, 16'h0103}, "word count");
        end
        $display("test bursts done");
        // Grant withheld in every mode
        grantDelay <= 16'd1000;
        for (m = 0; m < 4; m = m + 1) begin
            apb(1'b1, `OFF_CTRL, 32'h18 | m);
            xfer(1'b0, `SEQ_DATA, 8'h00);
            chk(gotTmo, 1, "timeout");
            rd(`OFF_STATUS, {28'h0, m != 3, 1'b0, m == 0, 1'b1});
            chk(obs, {1'b0, m == 3, m < 2, m != 3, m != 3}, "effects");
            chk({hsFailIrq, keepErrorCheck, xferReady}, {1'b1, m == 1, m != 0}, "flags");
            rd(`OFF_BITWORD, m == 1);
            rd(`OFF_BLKSTAT, (m != 3) ? 3 : 0);
            apb(1'b1, `OFF_STATUS, 32'h3);
            apb(1'b1, `OFF_BITWORD, 32'h1);
            apb(1'b1, `OFF_BLKSTAT, 32'h3);
            messageStart <= 1'b1;
            @(posedge clk);
            messageStart <= 1'b0;
            @(posedge clk);
            chk(storeInhibit, 0, "store inhibit");
        end
        // Message-start timeout in remote terminal mode drops the message
        apb(1'b1, `OFF_CTRL, 32'h19);
        xfer(1'b0, `SEQ_SOM, 8'h00);
        apb(1'b1, `OFF_STATUS, 32'h3);
        chk({gotTmo, obs[4]}, 2'b11, "start timeout");
        $display("test grant timeout done");
        // Host strobe held low: times out only when shared and in a guarded word;
        // the last pass is a short 40 ns strobe, which must never time out
        for (k = 0; k < 4; k = k + 1) begin
            apb(1'b1, `OFF_CTRL, (k == 0) ? 32'h11 : 32'h15);
            hostStrobeN <= 1'b0;
            hostHandshakeN <= 1'b0;
            if (k == 3) begin
                repeat (2) @(posedge clk);
                hostStrobeN <= 1'b1;
                hostHandshakeN <= 1'b1;
            end
            xfer(1'b0, (k == 2) ? `SEQ_EOM : `SEQ_DATA, 8'h03);
            hostStrobeN <= 1'b1;
            hostHandshakeN <= 1'b1;
            chk({gotDone, gotTmo}, {k != 1, k == 1}, "strobe hold");
            apb(1'b1, `OFF_STATUS, 32'h3);
        end
        $display("test strobe timeout done");
        final_report;
    end
endmodule
